/* File: include/host_io_pkg.sv */
/*
  Shared constants and carrier types for the host I/O port registers.
  Assumes a single 125 MHz system clock and a synchronous, active-high
  reset; the host bus logic runs on the same clock.
*/

package host_io_pkg;

  // ---------------------------------------------------------------
  // I/O port map
  // ---------------------------------------------------------------
  localparam logic [7:0] SWITCH_ROW_STATUS_ADDR    = 8'h00;
  localparam logic [7:0] BIT_LATCH_CONTROL_ADDR    = 8'h01;
  localparam logic [7:0] ENCODER_FOOTSWITCH_ADDR   = 8'h10;
  localparam logic [7:0] LED_COLUMN_RIGHT_ADDR     = 8'h41;
  localparam logic [7:0] LED_LEFT_ROWS_ADDR        = 8'h61;
  localparam logic [7:0] LCD_MODE_CONTRAST_ADDR    = 8'h81;
  localparam logic [7:0] LCD_DATA_READ_ADDR        = 8'hC0;
  localparam logic [7:0] LCD_DATA_WRITE_ADDR       = 8'hC1;

  // Control latch window: upper three address bits, set/clear, index.
  localparam logic [2:0] CONTROL_REGION            = 3'h0;
  localparam int         CONTROL_SET_BIT           = 1;
  localparam int         CONTROL_INDEX_LSB         = 2;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int COUNTER_CLEAR_BIT   = 3;
  localparam int RESERVED_TEST_BIT   = 4;
  localparam int TX_READY_BIT        = 0;
  localparam int RX_READY_BIT        = 1;
  localparam int FRAMING_FAULT_BIT   = 2;
  localparam int DIGITAL_INPUT_PRESENT_BIT   = 3;
  localparam int COLUMN_LSB          = 0;
  localparam int RIGHT_ROWS_LSB      = 3;
  localparam int DISPLAY_READ_BIT    = 4;
  localparam int DATA_SELECT_BIT     = 5;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] LATCH_RESET         = 8'h00;
  localparam logic [6:0] COLUMN_ROWS_RESET   = 7'h00;
  localparam logic [7:0] LEFT_ROWS_RESET     = 8'hFF;
  localparam logic [5:0] LCD_MODE_RESET      = 6'h00;
  localparam logic [4:0] COLUMN_SELECT_IDLE  = 5'h1F;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ            = 125;
  localparam int TX_READY_MAX_NS    = 1000;
  localparam int TX_READY_CYCLES    = TX_READY_MAX_NS * CLK_MHZ / 1000;
  localparam int TX_COUNT_WIDTH     = 7;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] switch_row;
    logic       encoder_phase_a;
    logic       encoder_phase_b;
    logic       footswitch_tip;
    logic       footswitch_ring;
  } panel_inputs_type;

  typedef struct packed {
    logic [4:0] column_select_n;
    logic [3:0] right_rows;
    logic [7:0] left_rows_n;
  } led_drive_type;

  typedef struct packed {
    logic [3:0] contrast_code_bit;
    logic       display_read_next;
    logic       display_data_select;
  } lcd_mode_type;

endpackage : host_io_pkg

/* File: logic/bit_synchronizer.sv */
/*
  Two-stage synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level; no bus coherence across bits.
*/

`timescale 1ns/1ps
`default_nettype none

module bit_synchronizer #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : bit_synchronizer

`default_nettype wire

/* File: logic/host_io_port_registers.sv */
/*
  Host-visible port registers: I/O-space status and write latches, and
  the second memory-mapped logic register (bus release, status read).
  Assumes host strobes are on clk_sys and panel pins are asynchronous.
*/

`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Counter-clear bit stops frame clock.
// - Any register-two write releases the bus.
// - Receive ready flag, cleared by data read.
// - Framing fault refreshed per received byte.
// - Input-present flag held until relock.
// - Odd addresses write, even addresses read.
// - Fixed I/O address decode map.
// - Status ports return switches, encoder, footswitch.
// - Control latch sets or clears one bit.
// - Control latch outputs zero during reset.
// - First display latch: column and rows.
// - Right rows high, left rows low active.
// - Display latches capture on strobe trailing edge.
// - Column bits decode to active-low selects.
// - Low nibble drives the contrast code.
module host_io_port_registers (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic                          io_rd,
  input  wire logic                          io_wr,
  input  wire logic [7:0]                    io_addr,
  input  wire logic [7:0]                    io_wdata,
  input  wire logic [7:0]                    lcd_rdata,
  input  wire logic                          reg2_wr,
  input  wire logic [7:0]                    reg2_wdata,
  input  wire logic                          uart_tx_write,
  input  wire logic                          uart_rx_byte,
  input  wire logic                          uart_rx_framing,
  input  wire logic                          uart_data_rd,
  input  wire logic                          spdif_preamble,
  input  wire logic                          relock_set,
  input  wire host_io_pkg::panel_inputs_type panel_pins,
  output var  logic [7:0]                    io_rdata,
  output var  logic                          io_dir_write,
  output var  logic                          lcd_strobe,
  output var  logic [7:0]                    lcd_wdata,
  output var  logic [7:0]                    uart_digin_status,
  output var  logic                          bus_release,
  output var  logic                          frame_clock_enable,
  output var  logic                          reserved_test_bit,
  output var  logic [7:0]                    control_latch,
  output var  host_io_pkg::led_drive_type    led_drive,
  output var  host_io_pkg::lcd_mode_type     lcd_mode
);

  // ---------------------------------------------------------------
  // Local constants and helpers
  // ---------------------------------------------------------------
  localparam int TX_BOUND = host_io_pkg::TX_READY_CYCLES;
  // The status register adds one cycle, so the count stops one short.
  localparam logic [host_io_pkg::TX_COUNT_WIDTH-1:0] TX_LAST =
    host_io_pkg::TX_COUNT_WIDTH'(host_io_pkg::TX_READY_CYCLES - 2);

  // Column codes 1 to 5 each pull one select low; others leave all idle.
  function automatic logic [4:0] column_select(input logic [2:0] code);
    logic [4:0] sel;
    sel = host_io_pkg::COLUMN_SELECT_IDLE;
    if (code != 3'h0 && code <= 3'h5) begin
      sel[code - 3'h1] = 1'b0;
    end
    return sel;
  endfunction : column_select

  function automatic logic in_control_region(input logic [7:0] addr);
    return addr[7:5] == host_io_pkg::CONTROL_REGION;
  endfunction : in_control_region

  // ---------------------------------------------------------------
  // Panel input synchronisation
  // ---------------------------------------------------------------
  host_io_pkg::panel_inputs_type panel_sync;

  bit_synchronizer #(
    .WIDTH ($bits(host_io_pkg::panel_inputs_type))
  ) panel_sync_inst (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in (panel_pins),
    .sync_out (panel_sync)
  );

  // ---------------------------------------------------------------
  // I/O write strobe tracking
  // ---------------------------------------------------------------
  // The address and data are captured while the strobe is high so the
  // trailing edge sees the values of the last strobe cycle.
  logic       wr_active_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic       wr_trailing;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_active_reg <= 1'b0;
      wr_addr_reg   <= 8'h00;
      wr_data_reg   <= 8'h00;
    end else begin
      wr_active_reg <= io_wr;
      if (io_wr) begin
        wr_addr_reg <= io_addr;
        wr_data_reg <= io_wdata;
      end
    end
  end

  assign wr_trailing = wr_active_reg && !io_wr && wr_addr_reg[0];

  // ---------------------------------------------------------------
  // Transceiver direction
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      io_dir_write <= 1'b0;
    end else if (io_rd || io_wr) begin
      io_dir_write <= io_addr[0];
    end
  end

  // ---------------------------------------------------------------
  // I/O read decode
  // ---------------------------------------------------------------
  // Reads at odd addresses and unmapped even addresses return zero,
  // since the transceiver would face the wrong way for them.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      unique case (io_addr)
        host_io_pkg::SWITCH_ROW_STATUS_ADDR:
          io_rdata <= {4'h0, panel_sync.switch_row};
        host_io_pkg::ENCODER_FOOTSWITCH_ADDR:
          io_rdata <= {4'h0, panel_sync.footswitch_ring,
                       panel_sync.footswitch_tip,
                       panel_sync.encoder_phase_b,
                       panel_sync.encoder_phase_a};
        host_io_pkg::LCD_DATA_READ_ADDR:
          io_rdata <= lcd_rdata;
        default:
          io_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // LCD data access
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lcd_strobe <= 1'b0;
      lcd_wdata  <= 8'h00;
    end else begin
      lcd_strobe <= (io_rd && io_addr == host_io_pkg::LCD_DATA_READ_ADDR)
                 || (io_wr && io_addr == host_io_pkg::LCD_DATA_WRITE_ADDR);
      if (io_wr && io_addr == host_io_pkg::LCD_DATA_WRITE_ADDR) begin
        lcd_wdata <= io_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Bit-addressable control latch
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      control_latch <= host_io_pkg::LATCH_RESET;
    end else if (wr_trailing && in_control_region(wr_addr_reg)) begin
      control_latch[wr_addr_reg[host_io_pkg::CONTROL_INDEX_LSB +: 3]]
        <= wr_addr_reg[host_io_pkg::CONTROL_SET_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Display latches
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      led_drive.column_select_n <= host_io_pkg::COLUMN_SELECT_IDLE;
      led_drive.right_rows      <= host_io_pkg::COLUMN_ROWS_RESET[6:3];
    end else if (wr_trailing
                 && wr_addr_reg == host_io_pkg::LED_COLUMN_RIGHT_ADDR) begin
      led_drive.column_select_n <=
        column_select(wr_data_reg[host_io_pkg::COLUMN_LSB +: 3]);
      led_drive.right_rows <=
        wr_data_reg[host_io_pkg::RIGHT_ROWS_LSB +: 4];
    end
  end

  // Left rows reset to all ones so that no left LED lights after reset.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      led_drive.left_rows_n <= host_io_pkg::LEFT_ROWS_RESET;
    end else if (wr_trailing
                 && wr_addr_reg == host_io_pkg::LED_LEFT_ROWS_ADDR) begin
      led_drive.left_rows_n <= wr_data_reg;
    end
  end

  // ---------------------------------------------------------------
  // LCD mode and contrast latch
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lcd_mode <= host_io_pkg::LCD_MODE_RESET;
    end else if (wr_trailing
                 && wr_addr_reg == host_io_pkg::LCD_MODE_CONTRAST_ADDR) begin
      lcd_mode.contrast_code_bit   <= wr_data_reg[3:0];
      lcd_mode.display_read_next   <=
        wr_data_reg[host_io_pkg::DISPLAY_READ_BIT];
      lcd_mode.display_data_select <=
        wr_data_reg[host_io_pkg::DATA_SELECT_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Second logic register, write side
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_release <= 1'b0;
    end else begin
      bus_release <= reg2_wr;
    end
  end

  // The counter-clear bit is a level: the clocks stay stopped until a
  // later write with the bit low, which lets the DSP be resynchronised.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frame_clock_enable <= 1'b1;
      reserved_test_bit  <= 1'b0;
    end else if (reg2_wr) begin
      frame_clock_enable <=
        !reg2_wdata[host_io_pkg::COUNTER_CLEAR_BIT];
      reserved_test_bit  <=
        reg2_wdata[host_io_pkg::RESERVED_TEST_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Second logic register, status side
  // ---------------------------------------------------------------
  logic                                  tx_ready_reg;
  logic [host_io_pkg::TX_COUNT_WIDTH-1:0] tx_count_reg;
  logic                                  rx_ready_reg;
  logic                                  framing_reg;
  logic                                  digin_reg;

  // A write makes the flag busy, then a fixed count bounds the wait.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_ready_reg <= 1'b1;
      tx_count_reg <= '0;
    end else if (uart_tx_write) begin
      tx_ready_reg <= 1'b0;
      tx_count_reg <= '0;
    end else if (!tx_ready_reg) begin
      if (tx_count_reg == TX_LAST) begin
        tx_ready_reg <= 1'b1;
      end else begin
        tx_count_reg <= tx_count_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_ready_reg <= 1'b0;
    end else if (uart_rx_byte) begin
      rx_ready_reg <= 1'b1;
    end else if (uart_data_rd) begin
      rx_ready_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      framing_reg <= 1'b0;
    end else if (uart_rx_byte) begin
      framing_reg <= uart_rx_framing;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      digin_reg <= 1'b0;
    end else if (spdif_preamble) begin
      digin_reg <= 1'b1;
    end else if (relock_set) begin
      digin_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      uart_digin_status <= 8'h00;
    end else begin
      uart_digin_status <= {4'h0, digin_reg, framing_reg,
                            rx_ready_reg, tx_ready_reg};
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_tx_ready_bound: assert property (
    @(posedge clk_sys) disable iff (rst)
    uart_tx_write |=> !tx_ready_reg ##[1:TX_BOUND] tx_ready_reg)
    else $error("transmit ready not restored in time");

  chk_rx_ready_clear: assert property (
    @(posedge clk_sys) disable iff (rst)
    uart_data_rd && !uart_rx_byte |=> ##1
      !uart_digin_status[host_io_pkg::RX_READY_BIT])
    else $error("receive ready not cleared by data read");

  chk_framing_refresh: assert property (
    @(posedge clk_sys) disable iff (rst)
    uart_rx_byte |=> ##1
      uart_digin_status[host_io_pkg::FRAMING_FAULT_BIT]
        == $past(uart_rx_framing, 2)
      && uart_digin_status[host_io_pkg::RX_READY_BIT])
    else $error("framing fault not refreshed with byte");

  chk_digin_hold: assert property (
    @(posedge clk_sys) disable iff (rst)
    digin_reg && !relock_set |=> digin_reg)
    else $error("input present dropped without relock");

  chk_bus_release: assert property (
    @(posedge clk_sys) disable iff (rst)
    reg2_wr |=> bus_release ##1 (bus_release == $past(reg2_wr)))
    else $error("register two write did not release bus");

  chk_counter_clear: assert property (
    @(posedge clk_sys) disable iff (rst)
    reg2_wr && reg2_wdata[host_io_pkg::COUNTER_CLEAR_BIT]
      |=> !frame_clock_enable)
    else $error("counter clear did not stop frame clock");

  chk_dir_follow: assert property (
    @(posedge clk_sys) disable iff (rst)
    io_rd || io_wr |=> io_dir_write == $past(io_addr[0]))
    else $error("transceiver direction not following A0");

  chk_status_one: assert property (
    @(posedge clk_sys) disable iff (rst)
    io_rd && io_addr == host_io_pkg::SWITCH_ROW_STATUS_ADDR
      |=> io_rdata == {4'h0, $past(panel_sync.switch_row)})
    else $error("switch row status read wrong");

  chk_latch_reset: assert property (
    @(posedge clk_sys)
    rst |=> control_latch == host_io_pkg::LATCH_RESET)
    else $error("control latch not cleared by reset");

  chk_column_onehot: assert property (
    @(posedge clk_sys) disable iff (rst)
    $countones(~led_drive.column_select_n) <= 1)
    else $error("more than one column selected");

endmodule : host_io_port_registers

`default_nettype wire

/* File: testbench/host_bus_model.sv */
/*
  Host processor and DSP as seen from the second logic register and
  the UART strobes. Assumes the bench calls its tasks one at a time.
*/

`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] uart_digin_status,
  output var  logic       reg2_wr,
  output var  logic [7:0] reg2_wdata,
  output var  logic       uart_tx_write,
  output var  logic       uart_data_rd,
  output var  logic       timed_out
);
  initial begin
    reg2_wr = 1'b0;
    reg2_wdata = 8'h00;
    uart_tx_write = 1'b0;
    uart_data_rd = 1'b0;
    timed_out = 1'b0;
  end

  task automatic reg2_write(input logic [7:0] d);
    @(posedge clk_sys);
    reg2_wr <= 1'b1;
    reg2_wdata <= d;
    @(posedge clk_sys);
    reg2_wr <= 1'b0;
  endtask : reg2_write

  // bus handback
  // The DSP ends its tenure with a zero write.
  task automatic dsp_release();
    reg2_write(8'h00);
  endtask : dsp_release

  // wait for ready
  // Bounded so a stuck busy flag cannot hang the run.
  task automatic uart_send();
    int n;
    for (n = 0; n < 400 && uart_digin_status[0] !== 1'b1; n++) begin
      @(posedge clk_sys);
    end
    if (n >= 400) timed_out = 1'b1;
    @(posedge clk_sys);
    uart_tx_write <= 1'b1;
    @(posedge clk_sys);
    uart_tx_write <= 1'b0;
  endtask : uart_send

  // receive data read
  // Also used once after power-up to drop a stale ready flag.
  task automatic uart_read();
    @(posedge clk_sys);
    uart_data_rd <= 1'b1;
    @(posedge clk_sys);
    uart_data_rd <= 1'b0;
  endtask : uart_read
endmodule : host_bus_model

`default_nettype wire

/* File: testbench/tb.sv */
/*
  Self-checking bench for the host I/O port registers.
  Assumes host_io_pkg is compiled first and one 125 MHz clock.
*/

`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk_sys, rst, io_rd, io_wr, rx_b, rx_f, pre, relock, tmo;
  logic reg2_wr, tx_w, data_rd, io_dir_write, lcd_strobe, bus_release;
  logic fce, rtb;
  logic [7:0] io_addr, io_wdata, lcd_rdata, reg2_wdata, io_rdata;
  logic [7:0] lcd_wdata, st, control_latch, d, e8;
  logic [4:0] e5;
  host_io_pkg::panel_inputs_type panel_pins;
  host_io_pkg::led_drive_type led_drive;
  host_io_pkg::lcd_mode_type lcd_mode;
  int err_total, n_compared, n;

  host_io_port_registers dut (.clk_sys(clk_sys), .rst(rst),
    .io_rd(io_rd), .io_wr(io_wr), .io_addr(io_addr),
    .io_wdata(io_wdata), .lcd_rdata(lcd_rdata), .reg2_wr(reg2_wr),
    .reg2_wdata(reg2_wdata), .uart_tx_write(tx_w), .uart_rx_byte(rx_b),
    .uart_rx_framing(rx_f), .uart_data_rd(data_rd),
    .spdif_preamble(pre), .relock_set(relock), .panel_pins(panel_pins),
    .io_rdata(io_rdata), .io_dir_write(io_dir_write),
    .lcd_strobe(lcd_strobe), .lcd_wdata(lcd_wdata),
    .uart_digin_status(st), .bus_release(bus_release),
    .frame_clock_enable(fce), .reserved_test_bit(rtb),
    .control_latch(control_latch), .led_drive(led_drive),
    .lcd_mode(lcd_mode));

  host_bus_model host (.clk_sys(clk_sys), .uart_digin_status(st),
    .reg2_wr(reg2_wr), .reg2_wdata(reg2_wdata), .uart_tx_write(tx_w),
    .uart_data_rd(data_rd), .timed_out(tmo));

  // ------------------------------------------------------------
  // Clock and shared tasks
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [16:0] s, e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic io_write(input logic [7:0] a, dv);
    @(posedge clk_sys);
    io_wr <= 1'b1;
    io_addr <= a;
    io_wdata <= dv;
    @(posedge clk_sys);
    io_wr <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : io_write

  task automatic io_read(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_sys);
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    #1 q = io_rdata;
  endtask : io_read

  // Bits of m, high to low: received byte, preamble, relock.
  task automatic pulse(input logic [2:0] m);
    @(posedge clk_sys);
    {rx_b, pre, relock} <= m;
    @(posedge clk_sys);
    {rx_b, pre, relock} <= 3'h0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : pulse

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {io_rd, io_wr, rx_b, rx_f, pre, relock} = 6'h00;
    io_addr = 8'h00;
    io_wdata = 8'h00;
    lcd_rdata = 8'h5C;
    panel_pins = 8'hA6;
    err_total = 0;
    n_compared = 0;
    rst = 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("ctl_rst", 17'(control_latch), 17'h00);
    chk("led_rst", led_drive, {5'h1F, 4'h0, 8'hFF});
    chk("st_rst", 17'(st), 17'h01);
    chk("fce_rst", 17'(fce), 17'h1);
    host.uart_read();
    io_read(8'h00, d);
    chk("status1", 17'(d), 17'h0A);
    chk("dir_rd", 17'(io_dir_write), 17'h0);
    io_read(8'h10, d);
    chk("status2", 17'(d), 17'h06);
    io_read(8'h01, d);
    chk("odd_rd", 17'(d), 17'h00);
    e8 = 8'h00;
    for (n = 0; n < 8; n++) begin
      io_write({3'h0, n[2:0], 2'b11}, 8'h00);
      e8[n] = 1'b1;
      chk("ctl_set", 17'(control_latch), 17'(e8));
    end
    io_write(8'h0D, 8'h00);
    e8[3] = 1'b0;
    chk("ctl_clr", 17'(control_latch), 17'(e8));
    chk("dir_wr", 17'(io_dir_write), 17'h1);
    for (n = 0; n < 8; n++) begin
      io_write(8'h41, {1'b0, 4'h5, n[2:0]});
      e5 = (n >= 1 && n <= 5) ? ~(5'h01 << (n - 1)) : 5'h1F;
      chk("col_sel", 17'(led_drive.column_select_n), 17'(e5));
      chk("right", 17'(led_drive.right_rows), 17'h5);
    end
    io_write(8'h41, 8'h2B);
    chk("col_in", 17'(led_drive.column_select_n), 17'h1B);
    io_write(8'h61, 8'h3C);
    chk("left", 17'(led_drive.left_rows_n), 17'h3C);
    io_write(8'h60, 8'hC3);
    chk("even_wr", 17'(led_drive.left_rows_n), 17'h3C);
    io_write(8'h81, 8'h3B);
    chk("lcd_mode", 17'(lcd_mode), 17'h2F);
    io_write(8'hC1, 8'h96);
    chk("lcd_wd", 17'(lcd_wdata), 17'h96);
    io_read(8'hC0, d);
    chk("lcd_rd", 17'(d), 17'h5C);
    chk("lcd_stb", 17'(lcd_strobe), 17'h1);
    host.reg2_write(8'h08);
    #1 chk("release", 17'(bus_release), 17'h1);
    chk("fce_off", 17'(fce), 17'h0);
    @(posedge clk_sys);
    #1 chk("rel_end", 17'(bus_release), 17'h0);
    host.dsp_release();
    #1 chk("fce_on", 17'(fce), 17'h1);
    chk("test_bit", 17'(rtb), 17'h0);
    host.uart_send();
    repeat (2) @(posedge clk_sys);
    #1 chk("tx_busy", 17'(st[0]), 17'h0);
    // Cycles are counted from the edge that takes the UART write.
    for (n = 2; n < 300 && st[0] !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("tx_time", 17'(n <= host_io_pkg::TX_READY_CYCLES), 17'h1);
    rx_f <= 1'b1;
    pulse(3'h4);
    rx_f <= 1'b0;
    chk("rx_fault", 17'(st[2:1]), 17'h3);
    pulse(3'h4);
    chk("rx_ok", 17'(st[2:1]), 17'h1);
    host.uart_read();
    repeat (2) @(posedge clk_sys);
    #1 chk("rx_clr", 17'(st[1]), 17'h0);
    pulse(3'h2);
    chk("digin", 17'(st[3]), 17'h1);
    repeat (4) @(posedge clk_sys);
    #1 chk("digin_hold", 17'(st[3]), 17'h1);
    pulse(3'h1);
    chk("digin_clr", 17'(st[3]), 17'h0);
    if (tmo) err_total++;
    test_done();
  end
endmodule : tb

`default_nettype wire
